// [design/ats_pkg.sv]
package ats_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFF_STATUS  = 8'h00;
  localparam logic [7:0] OFF_COUNT   = 8'h04;
  localparam logic [7:0] OFF_COMPARE = 8'h08;
  localparam logic [7:0] OFF_CONTROL = 8'h0C;
  localparam logic [7:0] OFF_FLAGS   = 8'h10;
  localparam logic [7:0] OFF_ENABLE  = 8'h14;

  // Status field positions.
  localparam int STAT_ASYNC_BIT = 3;
  localparam int STAT_CNT_BUSY  = 2;
  localparam int STAT_CMP_BUSY  = 1;
  localparam int STAT_CTL_BUSY  = 0;

  // Control field positions.
  localparam int CTL_RUN_BIT   = 0;
  localparam int CTL_MODE_LO   = 1;
  localparam int CTL_CLEAR_BIT = 3;

  // Flag and enable field positions.
  localparam int FLG_COMPARE = 0;
  localparam int FLG_OVERFLOW = 1;

  // Holding latch indexes.
  localparam int H_CNT = 0;
  localparam int H_CMP = 1;
  localparam int H_CTL = 2;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_PAIR = 2'h0;

  // Timer clock edges before a held value reaches its destination.
  localparam logic [1:0] XFER_EDGES = 2'h2;
  // Processor cycles to move a timer event into the processor domain.
  localparam int FLAG_SYNC_CYCLES = 3;

  // Compare output actions.
  typedef enum logic [1:0] {
    ATS_OUT_NONE   = 2'h0,
    ATS_OUT_TOGGLE = 2'h1,
    ATS_OUT_CLEAR  = 2'h2,
    ATS_OUT_SET    = 2'h3
  } ats_out_mode_t;

  // One holding latch with its transfer state.
  typedef struct packed {
    logic       busy;
    logic [1:0] edges;
    logic [7:0] val;
  } ats_hold_t;

endpackage

// [design/ats_timer_sync.sv]
// How it works
// - Status bits 7..4 always read zero.
// - Mode bit picks system or oscillator clock.
// - Clock source change may corrupt timer registers.
// - Counter write sets busy until loaded.
// - Compare write sets busy until loaded.
// - Control write sets busy until loaded.
// - Counter reads live; others read latch.
// - Latched value moves after two timer edges.
// - Each register owns its holding latch.
// - No compare match while counter/compare pending.
// - Interrupt logic resets after one timer cycle.
// - Oscillator stops in power-down; wait.
// - Wake-up starts on next timer cycle.
// - Flags visible three processor cycles later.
// - Flag sync takes three cycles plus tick.
// - Compare pin driven on timer clock.
// - Counter write blocks next cycle's match.
//
// Implementation choices: the APB register port and the placing of the registers.
module ats_timer_sync (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Oscillator and power pins.
  input  wire logic        async_osc_input,
  input  wire logic        power_down,
  output logic             osc_pins_claimed,
  // Timer results.
  output logic             compare_out,
  output logic             timer_irq,
  output logic             wake_req
);

  // Pin synchronisers: oscillator pin (with an edge stage) and power-down request.
  // The pins are not related to clk, so no logic reads their first stage.
  logic [2:0] osc_q, osc_d;
  logic [1:0] pd_q, pd_d;

  // Clock source select; a change abandons every pending transfer.
  logic       async_q, async_d;

  // One holding latch per synchronised register, so the transfers never interfere.
  // Reads of compare and control come from here, which shows the newest write.
  ats_pkg::ats_hold_t hold_q [3];
  ats_pkg::ats_hold_t hold_d [3];

  // Timer core: counter, compare value and control byte in the timer's time base.
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] cmp_q, cmp_d;
  logic [7:0] ctl_q, ctl_d;

  // Match blocking after a counter load, and the compare output pin.
  logic       blk_q, blk_d;
  logic       cout_q, cout_d;

  // Event pipes that stand for the flag crossing into the processor domain.
  // They cost a few flops but keep the flag timing the same in every run.
  logic [ats_pkg::FLAG_SYNC_CYCLES-1:0] cpipe_q, cpipe_d, opipe_q, opipe_d;

  // Event flags, their enables and the interrupt line.
  logic [1:0] flags_q, flags_d;
  logic [1:0] en_q, en_d;
  logic       irq_q, irq_d;

  // Wake request: armed by an event, fired on the following timer tick.
  logic       wpend_q, wpend_d;
  logic       wake_q, wake_d;

  // Registered bus answer; read data is captured in the setup cycle.
  logic       rdy_q, rdy_d;
  logic       err_q, err_d;
  logic [31:0] rdata_q, rdata_d;

  // Values worked out in the next-state process and used within the same cycle.
  logic tick;
  logic match;
  logic ovf;
  logic wr;
  logic cmp_ev;
  logic ovf_ev;

  // Returns one when the address names a mapped register.
  // Unmapped addresses answer with an error and leave all state alone.
  function automatic logic ats_mapped(input logic [7:0] a);
    ats_mapped = (a == ats_pkg::OFF_STATUS) || (a == ats_pkg::OFF_COUNT) ||
                 (a == ats_pkg::OFF_COMPARE) || (a == ats_pkg::OFF_CONTROL) ||
                 (a == ats_pkg::OFF_FLAGS) || (a == ats_pkg::OFF_ENABLE);
  endfunction

  // Every output comes straight from a register.
  assign pready           = rdy_q;
  assign prdata           = rdata_q;
  assign pslverr          = err_q;
  assign osc_pins_claimed = async_q;
  assign compare_out      = cout_q;
  assign timer_irq        = irq_q;
  assign wake_req         = wake_q;

  // Next-state logic for the whole block.
  always_comb begin
    // Two-stage synchronisers; the third oscillator stage only serves edge detection.
    osc_d   = {osc_q[1:0], async_osc_input};
    pd_d    = {pd_q[0], power_down};
    // Every register keeps its value unless a branch below says otherwise.
    async_d = async_q;
    hold_d  = hold_q;
    cnt_d   = cnt_q;
    cmp_d   = cmp_q;
    ctl_d   = ctl_q;
    cout_d  = cout_q;
    en_d    = en_q;
    // oscillator clock select
    // The oscillator stops in power-down, so no oscillator ticks are taken then; in synchronous mode every clk is still a tick.
    // oscillator stopped
    tick = async_q ? (osc_q[1] & ~osc_q[2] & ~pd_q[1]) : 1'b1;
    // A write commits in the access cycle, when pready is high.
    wr   = psel & penable & rdy_q & pwrite;
    blk_d = blk_q & ~tick;
    match = tick & ctl_q[ats_pkg::CTL_RUN_BIT] & (cnt_q == cmp_q) & ~blk_q &
            ~hold_q[ats_pkg::H_CNT].busy & ~hold_q[ats_pkg::H_CMP].busy;
    // Overflow is seen when the counter leaves its top value.
    ovf   = tick & ctl_q[ats_pkg::CTL_RUN_BIT] & (cnt_q == 8'hFF);
    // The counter advances on every tick while the run bit is set.
    if (tick && ctl_q[ats_pkg::CTL_RUN_BIT]) begin
      cnt_d = cnt_q + 8'h01;
    end
    // Clear on match takes priority over the increment.
    if (match && ctl_q[ats_pkg::CTL_CLEAR_BIT]) begin
      cnt_d = 8'h00;
    end
    if (match) begin
      case (ats_pkg::ats_out_mode_t'(ctl_q[ats_pkg::CTL_MODE_LO +: 2]))
        ats_pkg::ATS_OUT_TOGGLE: cout_d = ~cout_q;
        ats_pkg::ATS_OUT_CLEAR:  cout_d = 1'b0;
        ats_pkg::ATS_OUT_SET:    cout_d = 1'b1;
        default:                 cout_d = cout_q;
      endcase
    end
    // A latch counts timer edges only while it is busy.
    // two edge transfer
    for (int i = 0; i < 3; i++) begin
      if (hold_q[i].busy && tick) begin
        if (hold_q[i].edges == ats_pkg::XFER_EDGES - 2'h1) begin
          hold_d[i].busy  = 1'b0;
          hold_d[i].edges = 2'h0;
          if (i == ats_pkg::H_CNT) begin
            cnt_d = hold_q[i].val;
            blk_d = 1'b1;
          end else if (i == ats_pkg::H_CMP) begin
            cmp_d = hold_q[i].val;
          end else begin
            ctl_d = hold_q[i].val;
          end
        end else begin
          hold_d[i].edges = hold_q[i].edges + 2'h1;
        end
      end
    end
    // In synchronous mode a write lands at once and busy never rises.
    // write sets busy
    if (wr) begin
      for (int i = 0; i < 3; i++) begin
        if (paddr == ats_pkg::OFF_COUNT + 8'(4 * i)) begin
          hold_d[i].val = pwdata[7:0];
          if (async_q) begin
            hold_d[i].busy  = 1'b1;
            hold_d[i].edges = 2'h0;
          end else if (i == ats_pkg::H_CNT) begin
            cnt_d = pwdata[7:0];
            blk_d = 1'b1;
          end else if (i == ats_pkg::H_CMP) begin
            cmp_d = pwdata[7:0];
          end else begin
            ctl_d = pwdata[7:0];
          end
        end
      end
      if (paddr == ats_pkg::OFF_STATUS) begin
        async_d = pwdata[ats_pkg::STAT_ASYNC_BIT];
      end
      if (paddr == ats_pkg::OFF_ENABLE) begin
        en_d = pwdata[1:0];
      end
    end
    // source change drops transfers
    // Pending transfers are abandoned; the old values may be stale.
    if (async_d != async_q) begin
      for (int i = 0; i < 3; i++) begin
        hold_d[i].busy  = 1'b0;
        hold_d[i].edges = 2'h0;
      end
    end
    // In synchronous mode the flags need no crossing and set at once.
    // three cycles plus tick
    cpipe_d = {cpipe_q[ats_pkg::FLAG_SYNC_CYCLES-2:0], match & async_q};
    opipe_d = {opipe_q[ats_pkg::FLAG_SYNC_CYCLES-2:0], ovf & async_q};
    cmp_ev = async_q ? cpipe_q[ats_pkg::FLAG_SYNC_CYCLES-1] : match;
    ovf_ev = async_q ? opipe_q[ats_pkg::FLAG_SYNC_CYCLES-1] : ovf;
    // A new event wins over a clear in the same cycle.
    flags_d = flags_q;
    if (wr && paddr == ats_pkg::OFF_FLAGS) begin
      flags_d = flags_q & ~pwdata[1:0];
    end
    flags_d[ats_pkg::FLG_COMPARE]  = flags_d[ats_pkg::FLG_COMPARE] | cmp_ev;
    flags_d[ats_pkg::FLG_OVERFLOW] = flags_d[ats_pkg::FLG_OVERFLOW] | ovf_ev;
    // The interrupt line follows the enabled flags one cycle later.
    irq_d = |(flags_q & en_q);
    // The wake pulse always lands on a tick, one tick after the event.
    // wake on next tick
    wake_d  = wpend_q & tick;
    wpend_d = (wpend_q & ~tick) | ((match | ovf) & async_q);
    // APB answers one cycle after setup with registered data.
    rdy_d   = psel & ~penable;
    err_d   = psel & ~penable & ~ats_mapped(paddr);
    rdata_d = rdata_q;
    if (psel && !penable) begin
      case (paddr)
        ats_pkg::OFF_STATUS:  rdata_d = {28'h0000000, async_q,
                                         hold_q[ats_pkg::H_CNT].busy,
                                         hold_q[ats_pkg::H_CMP].busy,
                                         hold_q[ats_pkg::H_CTL].busy};
        ats_pkg::OFF_COUNT:   rdata_d = {24'h000000, cnt_q};
        ats_pkg::OFF_COMPARE: rdata_d = {24'h000000, hold_q[ats_pkg::H_CMP].val};
        ats_pkg::OFF_CONTROL: rdata_d = {24'h000000, hold_q[ats_pkg::H_CTL].val};
        ats_pkg::OFF_FLAGS:   rdata_d = {30'h0, flags_q};
        ats_pkg::OFF_ENABLE:  rdata_d = {30'h0, en_q};
        default:              rdata_d = 32'h00000000;
      endcase
    end
  end

  // State registers; synchronous active-low reset.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      // Pending transfers and events are dropped along with everything else.
      osc_q   <= 3'h0;
      pd_q    <= 2'h0;
      async_q <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        hold_q[i] <= '0;
      end
      cnt_q   <= ats_pkg::RST_BYTE;
      cmp_q   <= ats_pkg::RST_BYTE;
      ctl_q   <= ats_pkg::RST_BYTE;
      blk_q   <= 1'b0;
      cout_q  <= 1'b0;
      cpipe_q <= '0;
      opipe_q <= '0;
      flags_q <= ats_pkg::RST_PAIR;
      en_q    <= ats_pkg::RST_PAIR;
      irq_q   <= 1'b0;
      wpend_q <= 1'b0;
      wake_q  <= 1'b0;
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      // Every register takes its next value on every edge.
      osc_q   <= osc_d;
      pd_q    <= pd_d;
      async_q <= async_d;
      hold_q  <= hold_d;
      cnt_q   <= cnt_d;
      cmp_q   <= cmp_d;
      ctl_q   <= ctl_d;
      blk_q   <= blk_d;
      cout_q  <= cout_d;
      cpipe_q <= cpipe_d;
      opipe_q <= opipe_d;
      flags_q <= flags_d;
      en_q    <= en_d;
      irq_q   <= irq_d;
      wpend_q <= wpend_d;
      wake_q  <= wake_d;
      rdy_q   <= rdy_d;
      err_q   <= err_d;
      rdata_q <= rdata_d;
    end
  end

endmodule

// [testbench/ats_osc_model.sv]
module ats_osc_model #(
  parameter int HALF_NS = 200
) (
  // Oscillator control and output.
  input wire logic run,
  output logic     osc
);
  timeunit 1ns;
  timeprecision 1ps;
  // stops in power-down
  // Free-running phase unrelated to clk; held low while stopped.
  initial begin
    osc = 1'h0;
    #3;
    forever begin
      #(HALF_NS);
      osc = run ? !osc : 1'h0;
    end
  end
endmodule

// [testbench/ats_props.sv]
module ats_props (
  // Clock, reset and bus.
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Timer pins.
  input wire logic        async_osc_input,
  input wire logic        power_down,
  input wire logic        osc_pins_claimed,
  input wire logic        compare_out,
  input wire logic        timer_irq,
  input wire logic        wake_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic       osc_q;
  logic       mode_w_q;
  logic [3:0] since_q;
  wire rd_st = pready && !pwrite && paddr == 8'h00;
  wire wr_acc = psel && penable && pready && pwrite;
  // Cycles since a raw oscillator rise; it saturates so it never wraps.
  always_ff @(posedge clk) begin
    osc_q    <= async_osc_input;
    mode_w_q <= pwdata[3];
    since_q  <= (async_osc_input && !osc_q) ? 4'h0 : since_q + {3'h0, since_q != 4'hF};
  end
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_map: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08,
    8'h0C, 8'h10, 8'h14})) else $error("pslverr wrong for address");
  a_rsvd_zero: assert property (rd_st |-> prdata[31:4] == 28'h0)
    else $error("reserved status bits set");
  a_busy_sync: assert property (rd_st && !osc_pins_claimed |-> prdata[2:0] == 3'h0)
    else $error("busy flag in sync mode");
  a_mode_claim: assert property (wr_acc && paddr == 8'h00 |=> osc_pins_claimed == mode_w_q)
    else $error("pins not following mode");
  a_mode_read: assert property (rd_st |-> prdata[3] == osc_pins_claimed)
    else $error("mode bit readback wrong");
  a_wake_tick: assert property (wake_req |-> osc_pins_claimed && since_q <= 4'h6)
    else $error("wake off a timer tick");
  a_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake pulse too long");
  a_pin_timer: assert property (osc_pins_claimed && $past(osc_pins_claimed) &&
    $changed(compare_out) |-> since_q <= 4'h6) else $error("pin moved off tick");
  c_wake: cover property (wake_req);
  c_irq: cover property ($rose(timer_irq));
  c_err: cover property (pready && pslverr);
endmodule

bind ats_timer_sync ats_props u_props (
  .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
  .async_osc_input, .power_down, .osc_pins_claimed, .compare_out, .timer_irq, .wake_req
);

// [testbench/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, power_down, er;
  logic osc, claimed, cmp_out, irq, wake;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  int error_cnt, comparisons, cyc;
  localparam logic [7:0] a_st = ats_pkg::OFF_STATUS, a_cnt = ats_pkg::OFF_COUNT;
  localparam logic [7:0] a_cmp = ats_pkg::OFF_COMPARE, a_ctl = ats_pkg::OFF_CONTROL;
  localparam logic [7:0] a_flg = ats_pkg::OFF_FLAGS, a_en = ats_pkg::OFF_ENABLE;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR at %0t: got %0h expected %0h", $time, g, e); end end
  ats_timer_sync dut (
    .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .async_osc_input(osc), .power_down, .osc_pins_claimed(claimed),
    .compare_out(cmp_out), .timer_irq(irq), .wake_req(wake)
  );
  ats_osc_model xtal (.run(!power_down), .osc);
  // Clock and hang guard.
  initial begin
    clk = 1'h0;
    forever #4 clk = !clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end
  task results;
    $display("errors %0d of %0d comparisons", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One APB transfer; the request stands until pready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    @(posedge clk);
  endtask
  // Returns just after a timer tick, far from the next one.
  task tick;
    @(posedge osc);
    repeat (6) @(posedge clk);
  endtask
  task t_reset;
    for (int i = 0; i < 6; i++) begin
      apb(1'h0, 8'(i * 4), '0);
      `CHK(rd, 32'h0)
    end
    apb(1'h0, 8'h18, '0);
    `CHK(er, 1'h1)
  endtask
  task t_status;
    apb(1'h1, a_st, 32'hFFFFFFFF);
    apb(1'h0, a_st, '0);
    `CHK(rd, 32'h08)
    `CHK(claimed, 1'h1)
    apb(1'h1, a_st, '0);
    `CHK(claimed, 1'h0)
  endtask
  task t_sync;
    apb(1'h1, a_cmp, 32'h40);
    apb(1'h1, a_en, 32'h1);
    apb(1'h1, a_ctl, 32'h03);
    apb(1'h1, a_cnt, 32'h40);
    apb(1'h0, a_flg, '0);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 300 && irq !== 1'h1; i++) @(posedge clk);
    `CHK(irq, 1'h1)
    `CHK(cmp_out, 1'h1)
    apb(1'h0, a_flg, '0);
    `CHK(rd, 32'h3)
    apb(1'h1, a_en, '0);
    apb(1'h1, a_ctl, '0);
    apb(1'h1, a_flg, 32'h3);
  endtask
  task t_async;
    apb(1'h1, a_st, 32'h08);
    tick;
    apb(1'h1, a_cnt, 32'hC0);
    apb(1'h0, a_st, '0);
    `CHK(rd, 32'h0C)
    tick;
    apb(1'h1, a_cmp, 32'hC2);
    apb(1'h1, a_ctl, 32'h03);
    apb(1'h0, a_st, '0);
    `CHK(rd, 32'h0F)
    apb(1'h0, a_cmp, '0);
    `CHK(rd, 32'hC2)
    tick;
    apb(1'h0, a_st, '0);
    `CHK(rd, 32'h0B)
    apb(1'h0, a_cnt, '0);
    `CHK(rd, 32'hC0)
    tick;
    apb(1'h0, a_st, '0);
    `CHK(rd, 32'h08)
    for (int i = 0; i < 300 && wake !== 1'h1; i++) @(posedge clk);
    `CHK(wake, 1'h1)
    repeat (4) @(posedge clk);
    apb(1'h0, a_flg, '0);
    `CHK(rd, 32'h1)
  endtask
  task t_power;
    apb(1'h0, a_st, '0);
    `CHK(rd, 32'h08)
    power_down <= 1'h1;
    apb(1'h0, a_cnt, '0);
    v = rd;
    repeat (120) @(posedge clk);
    apb(1'h0, a_cnt, '0);
    `CHK(rd, v)
    power_down <= 1'h0;
  endtask
  // Main sequence.
  initial begin
    {psel, penable, pwrite, power_down, rst_b} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    t_reset;
    t_status;
    t_sync;
    t_async;
    t_power;
    results();
  end
endmodule
